//--- logic/aom_top.sv
// output mode, drive current and encode clock control of the converter
`timescale 1ns/1ns
`default_nettype none
module aom_top (
  input wire logic i_clk,                              // core clock, 125 MHz
  input wire logic i_rst_n,                            // async reset, active low
  input wire logic i_encode_clock_true,                // encode clock, link domain
  input wire logic i_config_source_select,             // strap pin, high = parallel
  input wire logic i_par_sck_level,                    // serial clock pin level
  input wire logic i_par_cs_level,                     // chip select pin level
  input wire logic i_enc_comp_grounded,                // complement encode below threshold
  input wire aom_pkg::aom_omr_type i_output_mode_register, // serial mode register
  input wire logic i_clock_control_register,           // serial stabilizer enable
  input wire logic [aom_pkg::SAMPLE_W-1:0] i_sample,   // converted sample
  input wire logic i_sample_valid,                     // sample offered
  output logic o_sample_ready,                         // buffer has room
  output aom_pkg::aom_link_out_type o_link,            // pins toward the receiver
  output aom_pkg::aom_cfg_type o_active_cfg,           // resolved configuration
  output logic o_dcs_locked,                           // stabilizer on and locked
  output logic o_encode_stopped,                       // encode clock not seen
  output logic o_single_ended_encode                   // single-ended encode mode
);
  import aom_pkg::*;

  // helpers
  function automatic aom_out_mode_type legal_mode(input aom_out_mode_type m);
    legal_mode = (m == MODE_DDR_CMOS || m == MODE_DDR_LVDS) ? m : MODE_FULL_CMOS;
  endfunction

  function automatic logic [LANES-1:0] pick_bits(input logic [SAMPLE_W-1:0] w, input logic odd);
    pick_bits = '0;
    for (int i = 0; i < LANES; i++) begin
      pick_bits[i] = w[2*i + int'(odd)];
    end
  endfunction

  function automatic logic [5:0] abs_diff(input logic [5:0] a, input logic [5:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction

  // pin view of one word at a given output clock level
  function automatic aom_link_out_type drive(input aom_xfer_type x, input logic lvl);
    logic [LANES-1:0] lane;
    drive = LINK_OUT_RST;
    lane = pick_bits(x.sample, lvl);
    drive.lvds_current = x.cfg.lvds_current;
    unique case (x.cfg.mode)
      MODE_FULL_CMOS: begin
        drive.cmos_data = x.sample;
        drive.clk_true = lvl;
        drive.clk_comp = ~lvl;
      end
      MODE_DDR_CMOS: begin
        drive.cmos_data[LANES-1:0] = lane;
        drive.clk_true = lvl;
        drive.clk_comp = ~lvl;
      end
      MODE_DDR_LVDS: begin
        drive.lvds_p = lane;
        drive.lvds_n = ~lane;
        drive.lvds_clk_p = lvl;
        drive.lvds_clk_n = ~lvl;
      end
      default: drive = LINK_OUT_RST;
    endcase
  endfunction

  // core domain
  logic [3:0] pins_s;
  logic par;
  logic sck_lvl;
  logic cs_lvl;
  logic encgnd;
  aom_cfg_type cfg;
  aom_cfg_type next_cfg;
  aom_xfer_type xfer;
  logic req;
  logic unl_tgl;
  logic [3:0] back_s;
  logic ack_s;
  logic hb_s;
  logic lock_s;
  logic uecho_s;
  logic hb_d;
  logic [5:0] pcnt;
  logic [5:0] plast;
  logic stopped;
  logic fifo_valid;
  logic [SAMPLE_W-1:0] fifo_data;
  logic xfer_free;

  // link-domain state, declared here because the back synchroniser reads it
  logic lk_rst_n;
  logic [1:0] fwd_s;
  logic lk_req_s;
  logic lk_unl_s;
  logic lk_unl_d;
  logic lk_ph;
  logic lk_hb;
  logic lk_ack;
  logic lk_uecho;
  logic [6:0] lk_cnt;
  logic lk_locked;
  aom_xfer_type lk_cur;

  // pins are asynchronous to the core clock
  aom_sync2 #(.W(4)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_config_source_select, i_par_sck_level, i_par_cs_level, i_enc_comp_grounded}),
    .o_q(pins_s)
  );

  assign par = pins_s[3];
  assign sck_lvl = pins_s[2];
  assign cs_lvl = pins_s[1];
  assign encgnd = pins_s[0];

  // resolve the configuration from register or pin levels
  assign next_cfg.mode = par ? (sck_lvl ? MODE_DDR_LVDS : MODE_FULL_CMOS)
                             : legal_mode(i_output_mode_register.mode);
  assign next_cfg.lvds_current = (par || i_output_mode_register.lvds_current == CUR_ILLEGAL)
                                 ? CUR_DEFAULT : i_output_mode_register.lvds_current;
  assign next_cfg.dcs_enable = par ? cs_lvl : i_clock_control_register;

  aom_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_sample_valid),
    .i_in_data(i_sample),
    .o_in_ready(o_sample_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(fifo_data),
    .i_out_ready(xfer_free)
  );

  // link-to-core levels: ack, heartbeat, lock, unlock echo
  aom_sync2 #(.W(4)) u_back_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({lk_ack, lk_hb, lk_locked, lk_uecho}),
    .o_q(back_s)
  );

  assign ack_s = back_s[3];
  assign hb_s = back_s[2];
  assign lock_s = back_s[1];
  assign uecho_s = back_s[0];

  // words travel with their configuration, so a change lands on a boundary
  assign xfer_free = (req == ack_s);
  wire xfer_load = xfer_free & fifo_valid;
  wire hb_edge = hb_s ^ hb_d;
  // a period jump beyond the tolerance is taken as a frequency change
  wire freq_change = hb_edge && abs_diff(pcnt, plast) > PERIOD_TOL;
  wire dcs_rise = next_cfg.dcs_enable & ~cfg.dcs_enable;
  wire unlock = freq_change | (stopped & hb_edge) | dcs_rise;

  // configuration and handshake source
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg <= CFG_RST;
      xfer <= XFER_RST;
      req <= 1'b0;
    end else begin
      cfg <= next_cfg;
      if (xfer_load) begin
        xfer <= '{next_cfg, fifo_data};
        req <= ~req;
      end
    end
  end

  // encode clock watch: period in core cycles, stop timeout
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hb_d <= 1'b0;
      pcnt <= '0;
      plast <= '0;
      stopped <= 1'b1;
      unl_tgl <= 1'b0;
    end else begin
      hb_d <= hb_s;
      if (hb_edge) begin
        pcnt <= '0;
        plast <= pcnt;
      end else if (pcnt != 6'h3F) begin
        pcnt <= pcnt + 6'h01;
      end
      stopped <= hb_edge ? 1'b0 : (stopped | (pcnt >= ENC_STOP_CYCLES));
      if (unlock) begin
        unl_tgl <= ~unl_tgl;
      end
    end
  end

  // status outputs; lock only counts once the link has seen the latest restart
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_active_cfg <= CFG_RST;
      o_dcs_locked <= 1'b0;
      o_encode_stopped <= 1'b1;
      o_single_ended_encode <= 1'b0;
    end else begin
      o_active_cfg <= cfg;
      o_dcs_locked <= cfg.dcs_enable & lock_s & (uecho_s == unl_tgl) & ~stopped;
      o_encode_stopped <= stopped;
      o_single_ended_encode <= encgnd;
    end
  end

  // link domain

  // release of reset aligned to the encode clock
  aom_sync2 #(.W(1)) u_lk_rst (
    .i_clk(i_encode_clock_true),
    .i_rst_n(i_rst_n),
    .i_d(1'b1),
    .o_q(lk_rst_n)
  );

  aom_sync2 #(.W(2)) u_fwd_sync (
    .i_clk(i_encode_clock_true),
    .i_rst_n(lk_rst_n),
    .i_d({req, unl_tgl}),
    .o_q(fwd_s)
  );

  assign lk_req_s = fwd_s[1];
  assign lk_unl_s = fwd_s[0];

  // boundary when the output clock is about to fall
  wire lk_boundary = lk_ph;
  wire lk_take = lk_boundary & (lk_req_s != lk_ack);
  wire lk_unl_edge = lk_unl_s ^ lk_unl_d;
  wire [6:0] next_lk_cnt = lk_unl_edge ? 7'h00
                         : (lk_cnt == DCS_LOCK_CYCLES) ? lk_cnt : lk_cnt + 7'h01;
  // xfer is steady while the request is open, so sampling it here is safe
  wire aom_xfer_type next_lk_cur = lk_take ? xfer : lk_cur;

  // word capture and pin drive; old word repeats if none is waiting
  always_ff @(posedge i_encode_clock_true or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_ph <= 1'b0;
      lk_hb <= 1'b0;
      lk_ack <= 1'b0;
      lk_cur <= XFER_RST;
      o_link <= LINK_OUT_RST;
    end else begin
      lk_ph <= ~lk_ph;
      lk_hb <= ~lk_hb;
      if (lk_take) begin
        lk_ack <= ~lk_ack;
      end
      lk_cur <= next_lk_cur;
      o_link <= drive(next_lk_cur, ~lk_ph);
    end
  end

  // stabilizer lock counter in encode cycles
  always_ff @(posedge i_encode_clock_true or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lk_unl_d <= 1'b0;
      lk_uecho <= 1'b0;
      lk_cnt <= '0;
      lk_locked <= 1'b0;
    end else begin
      lk_unl_d <= lk_unl_s;
      lk_uecho <= lk_unl_s;
      lk_cnt <= next_lk_cnt;
      lk_locked <= next_lk_cnt == DCS_LOCK_CYCLES;
    end
  end

  // checks
  sequence s_unlock_seen;
    lk_unl_edge ##1 !lk_locked;
  endsequence

  a_par_no_ddr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    par |=> cfg.mode != MODE_DDR_CMOS) else $error("ddr cmos chosen from pins");

  a_par_sck_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    par && sck_lvl |=> cfg.mode == MODE_DDR_LVDS && cfg.lvds_current == CUR_DEFAULT)
    else $error("pin high did not give lvds at default current");

  a_par_cs_dcs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    par |=> cfg.dcs_enable == $past(cs_lvl)) else $error("stabilizer does not follow cs pin");

  a_ser_reg_mode: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !par && i_output_mode_register.mode == MODE_DDR_CMOS |=> cfg.mode == MODE_DDR_CMOS)
    else $error("register mode not applied");

  a_lock_count: assert property (@(posedge i_encode_clock_true) disable iff (!lk_rst_n)
    lk_locked |-> lk_cnt == DCS_LOCK_CYCLES) else $error("locked before 100 encode cycles");

  a_unlock_drop: assert property (@(posedge i_encode_clock_true) disable iff (!lk_rst_n)
    lk_unl_edge |-> s_unlock_seen) else $error("lock kept across restart");

  a_ddr_even_low: assert property (@(posedge i_encode_clock_true) disable iff (!lk_rst_n)
    next_lk_cur.cfg.mode == MODE_DDR_CMOS |=> o_link.clk_true
      ? o_link.cmos_data[LANES-1:0] == pick_bits($past(next_lk_cur.sample), 1'b1)
      : o_link.cmos_data[LANES-1:0] == pick_bits($past(next_lk_cur.sample), 1'b0))
    else $error("ddr lane carries wrong bit for clock level");

  a_full_fall: assert property (@(posedge i_encode_clock_true) disable iff (!lk_rst_n)
    $changed(o_link.cmos_data) && lk_cur.cfg.mode == MODE_FULL_CMOS && $past(lk_cur.cfg.mode) == MODE_FULL_CMOS
      |-> $fell(o_link.clk_true)) else $error("full-rate data moved off the clock fall");

  a_mode_boundary: assert property (@(posedge i_encode_clock_true) disable iff (!lk_rst_n)
    $changed(lk_cur.cfg) |-> !lk_ph) else $error("mode changed inside a sample");

  a_lvds_pair: assert property (@(posedge i_encode_clock_true) disable iff (!lk_rst_n)
    $past(next_lk_cur.cfg.mode) == MODE_DDR_LVDS |-> o_link.lvds_n == ~o_link.lvds_p
      && o_link.lvds_clk_n == ~o_link.lvds_clk_p) else $error("lvds pair not complementary");

  a_ddr_cmos_lanes: assert property (@(posedge i_encode_clock_true) disable iff (!lk_rst_n)
    $past(next_lk_cur.cfg.mode) == MODE_DDR_CMOS |-> o_link.cmos_data[SAMPLE_W-1:LANES] == '0
      && o_link.clk_comp == ~o_link.clk_true) else $error("ddr cmos drives more than its lanes");

  // register path and status checks; lock must never outrun its causes
  a_ser_current: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !par && i_output_mode_register.lvds_current != CUR_ILLEGAL
      |=> cfg.lvds_current == $past(i_output_mode_register.lvds_current))
    else $error("register current level not applied");

  a_ser_dcs_reg: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !par |=> cfg.dcs_enable == $past(i_clock_control_register))
    else $error("stabilizer does not follow its register");

  a_lock_needs_dcs: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_dcs_locked |-> $past(cfg.dcs_enable) && !$past(stopped))
    else $error("lock shown while stabilizer off or clock stopped");

  a_stop_no_lock: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_encode_stopped |-> !o_dcs_locked)
    else $error("lock shown while encode clock stopped");

  a_single_follow: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_single_ended_encode == $past(encgnd))
    else $error("single-ended flag does not follow pin");

endmodule
`default_nettype wire

//--- logic/aom_pkg.sv
// shared constants and types for the converter output mode control
// Function
// - serial mode registers select the optional features
// - three output modes, register or pin chosen
// - parallel pins never select double-rate cmos
// - full-rate cmos: 16 lanes plus clock pair
// - double-rate cmos: two bits per 8 lanes
// - double-rate lvds: 8 pairs, own clock pair
// - lvds drive current resets to 3.5mA
// - lvds current takes one of seven levels
// - stabilizer enable from register or pin
// - stabilizer accepts 30-70% duty, makes 50%; duty is not modelled here, only the lock delay
// - stabilizer relocks after 100 encode cycles
// - grounded complement input means single-ended encode
// - double-rate: even bits clock low, odd high
// - full-rate data changes on clock fall
// - parallel: sck low full cmos, high lvds
// - parallel: cs low stabilizer off, high on
package aom_pkg;

  localparam int SAMPLE_W = 16;
  localparam int LANES = 8;
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    MODE_FULL_CMOS = 2'h0,
    MODE_DDR_CMOS = 2'h1,
    MODE_DDR_LVDS = 2'h2
  } aom_out_mode_type;

  // lvds drive current codes, 3'h7 is not a level
  localparam logic [2:0] CUR_1MA75 = 3'h0;
  localparam logic [2:0] CUR_2MA1 = 3'h1;
  localparam logic [2:0] CUR_2MA5 = 3'h2;
  localparam logic [2:0] CUR_3MA0 = 3'h3;
  localparam logic [2:0] CUR_3MA5 = 3'h4;
  localparam logic [2:0] CUR_4MA0 = 3'h5;
  localparam logic [2:0] CUR_4MA5 = 3'h6;
  localparam logic [2:0] CUR_ILLEGAL = 3'h7;
  localparam logic [2:0] CUR_DEFAULT = CUR_3MA5;

  typedef struct packed {
    aom_out_mode_type mode;
    logic [2:0] lvds_current;
  } aom_omr_type;

  typedef struct packed {
    aom_out_mode_type mode;
    logic [2:0] lvds_current;
    logic dcs_enable;
  } aom_cfg_type;

  typedef struct packed {
    aom_cfg_type cfg;
    logic [SAMPLE_W-1:0] sample;
  } aom_xfer_type;

  typedef struct packed {
    logic [SAMPLE_W-1:0] cmos_data;
    logic clk_true;
    logic clk_comp;
    logic [LANES-1:0] lvds_p;
    logic [LANES-1:0] lvds_n;
    logic lvds_clk_p;
    logic lvds_clk_n;
    logic [2:0] lvds_current;
  } aom_link_out_type;

  localparam aom_cfg_type CFG_RST = '{MODE_FULL_CMOS, CUR_DEFAULT, 1'b0};
  localparam aom_xfer_type XFER_RST = '{CFG_RST, 16'h0000};
  localparam aom_link_out_type LINK_OUT_RST = '0;

  // stabilizer lock and encode clock watch
  localparam logic [6:0] DCS_LOCK_CYCLES = 7'h64;
  localparam int CLK_PERIOD_NS = 8;
  localparam int ENC_STOP_NS = 200;
  localparam logic [5:0] ENC_STOP_CYCLES = 6'((ENC_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] PERIOD_TOL = 6'h2;

endpackage

//--- logic/aom_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module aom_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,          // destination clock
  input wire logic i_rst_n,        // async reset, active low
  input wire logic [W-1:0] i_d,    // foreign level
  output logic [W-1:0] o_q         // synchronised level
);

  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end

endmodule
`default_nettype wire

//--- logic/aom_fifo.sv
// sample buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module aom_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,                // core clock
  input wire logic i_rst_n,              // async reset, active low
  input wire logic i_in_valid,           // writer has a word
  input wire logic [WIDTH-1:0] i_in_data, // word to store
  output logic o_in_ready,               // room left, registered
  output logic o_out_valid,              // word available, registered
  output logic [WIDTH-1:0] o_out_data,   // head word
  input wire logic i_out_ready           // reader takes head
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = i_in_valid & o_in_ready;
  wire pop = o_out_valid & i_out_ready;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign o_out_data = mem[rd_ptr];

  // flags registered from the next count so ready stays a flop
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_in_ready <= 1'b1;
      o_out_valid <= 1'b0;
    end else begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      count <= next_count;
      o_in_ready <= next_count != (AW+1)'(DEPTH);
      o_out_valid <= next_count != '0;
    end
  end

  // storage, no reset needed
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

endmodule
`default_nettype wire

//--- test/aom_rx_model.sv
// receiving logic model: rebuilds sample words from the link pins
`timescale 1ns/1ns
`default_nettype none
module aom_rx_model
  import aom_pkg::*;
(
  input wire logic i_link_clk,         // encode clock, outputs launch on its rise
  input wire aom_link_out_type i_link, // pins from the converter
  input wire logic i_ddr_cmos,         // receiver set up for double-rate cmos
  output logic o_stb,                  // new word rebuilt
  output logic [15:0] o_word,          // rebuilt word
  output logic [2:0] o_current,        // drive current seen with it
  output int o_fmt_err                 // pin format faults
);
  logic lvds;
  logic ck;
  logic [7:0] lanes;
  logic [15:0] part;
  logic [15:0] last;
  logic [15:0] prev;

  // lvds recognised by its clock pair, never both low while active
  assign lvds = i_link.lvds_clk_p | i_link.lvds_clk_n;
  assign ck = lvds ? i_link.lvds_clk_p : i_link.clk_true;
  assign lanes = lvds ? i_link.lvds_p : i_link.cmos_data[7:0];

  initial begin
    o_stb = 1'b0;
    o_word = '0;
    o_current = '0;
    o_fmt_err = 0;
    last = '0;
    part = '0;
    prev = '0;
  end

  // sample at the falling encode edge, half a cycle clear of launch
  always @(negedge i_link_clk) begin
    o_stb <= 1'b0;
    if (lvds && (i_link.lvds_n !== ~i_link.lvds_p || i_link.lvds_clk_n !== ~i_link.lvds_clk_p)) begin
      o_fmt_err = o_fmt_err + 1;
    end
    if (!lvds && ck && i_link.clk_comp !== ~ck) begin
      o_fmt_err = o_fmt_err + 1;
    end
    if (!lvds && !i_ddr_cmos && ck && i_link.cmos_data !== prev) begin
      o_fmt_err = o_fmt_err + 1;
    end
    prev = i_link.cmos_data;
    for (int i = 0; i < 8; i++) begin
      if (ck) part[2*i+1] = lanes[i];
      else part[2*i] = lanes[i];
    end
    if (ck) begin
      if (!lvds && !i_ddr_cmos) part = i_link.cmos_data;
      // a repeated word means no new sample, so it is not reported again
      if (part !== last) begin
        last = part;
        o_word <= part;
        o_current <= i_link.lvds_current;
        o_stb <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/tb_adc_output_mode_control.sv
// self-checking bench for the converter output mode control
`timescale 1ns/1ns
`default_nettype none
module tb_adc_output_mode_control;
  import aom_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic enc = 1'b0;
  logic enc_run = 1'b1;
  logic sel = 1'b0, sck = 1'b0, cs = 1'b0, gnd = 1'b0, ccr = 1'b0, valid = 1'b0, ddr = 1'b0;
  aom_omr_type omr = '{MODE_FULL_CMOS, CUR_DEFAULT};
  logic [15:0] sample = 16'h0000;
  logic [15:0] last_w = 16'h0000;
  logic ready, locked, stopped, single, rx_stb;
  aom_link_out_type link;
  aom_cfg_type cfg;
  logic [15:0] rx_word;
  logic [2:0] rx_cur;
  int fmt_err;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [3:0] exp_tag = 4'h0;
  logic [19:0] exp_q[$];
  logic [19:0] e;
  logic saw_full;

  aom_top DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_encode_clock_true(enc), .i_config_source_select(sel),
    .i_par_sck_level(sck), .i_par_cs_level(cs), .i_enc_comp_grounded(gnd), .i_output_mode_register(omr),
    .i_clock_control_register(ccr), .i_sample(sample), .i_sample_valid(valid), .o_sample_ready(ready),
    .o_link(link), .o_active_cfg(cfg), .o_dcs_locked(locked), .o_encode_stopped(stopped),
    .o_single_ended_encode(single));
  aom_rx_model RX (.i_link_clk(enc), .i_link(link), .i_ddr_cmos(ddr), .o_stb(rx_stb), .o_word(rx_word),
    .o_current(rx_cur), .o_fmt_err(fmt_err));

  // core clock, and an encode clock of another phase that can be halted
  always #4 i_clk = ~i_clk;
  initial begin
    #5;
    forever #24 enc = enc_run ? ~enc : enc; // well above the stabilizer floor
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // every rebuilt word is held against the oldest word accepted
  always @(posedge rx_stb) begin
    if (exp_q.size() == 0) chk(1, 0);
    else begin
      e = exp_q.pop_front();
      chk(rx_word, e[15:0]);
      if (e[19]) chk(rx_cur, e[18:16]);
    end
  end

  // back-to-back distinct words, held while refused; waits for the link to drain
  task automatic burst(input int n);
    saw_full = 1'b0;
    for (int k = 0; k < n; k++) begin
      last_w = 16'($urandom()) | 16'h0001;
      if (last_w == sample) last_w = last_w ^ 16'h0002;
      sample <= last_w;
      valid <= 1'b1;
      @(negedge i_clk);
      while (!ready) begin
        saw_full = 1'b1;
        @(negedge i_clk);
      end
      @(posedge i_clk);
      exp_q.push_back({exp_tag, last_w});
    end
    valid <= 1'b0;
    for (int k = 0; k < 600 && exp_q.size() > 0; k++) @(posedge i_clk);
    chk(exp_q.size(), 0);
  endtask

  task automatic settle();
    repeat (8) @(posedge i_clk);
  endtask

  initial begin
    void'($urandom(32'h1AC0));
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    chk(cfg, CFG_RST);
    repeat (10) @(posedge i_clk);
    // full-rate cmos, overfilled so the buffer refuses
    burst(14);
    chk(saw_full, 1);
    // every current code in lvds, the unmapped one falls back
    for (int c = 0; c < 8; c++) begin
      omr <= '{MODE_DDR_LVDS, 3'(c)};
      settle();
      chk(cfg.mode, MODE_DDR_LVDS);
      chk(cfg.lvds_current, (c == 7) ? CUR_DEFAULT : 3'(c));
      exp_tag = {1'b1, ((c == 7) ? CUR_DEFAULT : 3'(c))};
      if (c == 1 || c == 6) burst(4);
    end
    exp_tag = 4'h0;
    omr <= '{MODE_DDR_CMOS, CUR_DEFAULT};
    ddr = 1'b1;
    settle();
    chk(cfg.mode, MODE_DDR_CMOS);
    burst(6);
    // parallel pins: ddr cmos in the register must not win
    sel <= 1'b1;
    sck <= 1'b1;
    cs <= 1'b1;
    settle();
    chk(cfg, {MODE_DDR_LVDS, CUR_DEFAULT, 1'b1});
    exp_tag = {1'b1, CUR_DEFAULT};
    burst(4);
    // receiver leaves ddr cmos only once lvds words replaced the last ddr word
    ddr = 1'b0;
    exp_tag = 4'h0;
    sck <= 1'b0;
    cs <= 1'b0;
    settle();
    chk(cfg, {MODE_FULL_CMOS, CUR_DEFAULT, 1'b0});
    burst(4);
    // serial stabilizer enable and its lock delay
    sel <= 1'b0;
    ccr <= 1'b1;
    settle();
    chk(cfg.dcs_enable, 1);
    repeat (90) @(posedge enc);
    chk(locked, 0);
    for (int k = 0; k < 30 && !locked; k++) @(posedge enc);
    chk(locked, 1);
    // halt the encode clock, then restart and relock
    enc_run = 1'b0;
    repeat (40) @(posedge i_clk);
    chk(stopped, 1);
    chk(locked, 0);
    enc_run = 1'b1;
    repeat (90) @(posedge enc);
    chk(stopped, 0);
    chk(locked, 0);
    for (int k = 0; k < 30 && !locked; k++) @(posedge enc);
    chk(locked, 1);
    ccr <= 1'b0;
    settle();
    chk({cfg.dcs_enable, locked}, 0);
    // mode code 3 is no mode and falls back to full-rate
    omr <= '{aom_out_mode_type'(2'h3), CUR_DEFAULT};
    settle();
    chk(cfg.mode, MODE_FULL_CMOS);
    burst(2);
    // grounded complement input
    gnd <= 1'b1;
    settle();
    chk(single, 1);
    gnd <= 1'b0;
    settle();
    chk(single, 0);
    chk(fmt_err, 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
